// [apt_pkg.sv]
// Constants for the dual-slope timer with crystal-clocked update path.
// Assumes a 32-bit AXI4-Lite master with word-aligned accesses.
package apt_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTL_A  = 8'h00;
   localparam logic [7:0] OFS_CTL_B  = 8'h04;
   localparam logic [7:0] OFS_COUNT  = 8'h08;
   localparam logic [7:0] OFS_CMP_A  = 8'h0C;
   localparam logic [7:0] OFS_CMP_B  = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_FLAGS  = 8'h18;
   localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
   localparam logic [7:0] OFS_GEN    = 8'h20;
   // Buffered register slots, in order
   localparam int          NBUF      = 5;
   localparam logic [2:0]  SL_CTL_A  = 3'h0;
   localparam logic [2:0]  SL_CTL_B  = 3'h1;
   localparam logic [2:0]  SL_COUNT  = 3'h2;
   localparam logic [2:0]  SL_CMP_A  = 3'h3;
   localparam logic [2:0]  SL_CMP_B  = 3'h4;
   // Field positions
   localparam int          ACT_A_LSB = 6;
   localparam int          ACT_B_LSB = 4;
   localparam int          WGM2_BIT  = 3;
   localparam int          STS_ASYNC = 5;
   localparam int          GEN_PSR   = 1;
   // Modes and actions
   localparam logic [2:0]  WGM_PC_FF = 3'h1;
   localparam logic [2:0]  WGM_PC_CA = 3'h5;
   localparam logic [1:0]  ACT_TOG   = 2'h1;
   localparam logic [1:0]  ACT_NINV  = 2'h2;
   localparam logic [1:0]  ACT_INV   = 2'h3;
   localparam logic [7:0]  CNT_MAX   = 8'hFF;
   localparam logic [7:0]  CNT_BOT   = 8'h00;
   // Crystal edges before a held value lands, minus one
   localparam logic [1:0]  XT_LAST   = 2'h1;
   // Processor cycles of flag resynchronisation
   localparam int          FLG_DLY   = 3;
   // Prescaler tap masks per clock select code
   localparam logic [9:0]  PM_1      = 10'h000;
   localparam logic [9:0]  PM_8      = 10'h007;
   localparam logic [9:0]  PM_32     = 10'h01F;
   localparam logic [9:0]  PM_64     = 10'h03F;
   localparam logic [9:0]  PM_128    = 10'h07F;
   localparam logic [9:0]  PM_256    = 10'h0FF;
   localparam logic [9:0]  PM_1024   = 10'h3FF;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;
endpackage

// [apt_timer.sv]
// Dual-slope PWM timer, two compare channels, crystal-clocked update path.
// Assumes the crystal pin level is sampled on mclk_i, which runs well over
// four times the crystal rate.
`timescale 1ns/1ns
`default_nettype none
module apt_timer (
   // Clock and reset
   input  wire  logic        mclk_i,
   input  wire  logic        rstn_i,
   // AXI4-Lite write
   input  wire  logic [7:0]  s_axi_awaddr_i,
   input  wire  logic        s_axi_awvalid_i,
   output var   logic        s_axi_awready_o,
   input  wire  logic [31:0] s_axi_wdata_i,
   input  wire  logic [3:0]  s_axi_wstrb_i,
   input  wire  logic        s_axi_wvalid_i,
   output var   logic        s_axi_wready_o,
   output var   logic [1:0]  s_axi_bresp_o,
   output var   logic        s_axi_bvalid_o,
   input  wire  logic        s_axi_bready_i,
   // AXI4-Lite read
   input  wire  logic [7:0]  s_axi_araddr_i,
   input  wire  logic        s_axi_arvalid_i,
   output var   logic        s_axi_arready_o,
   output var   logic [31:0] s_axi_rdata_o,
   output var   logic [1:0]  s_axi_rresp_o,
   output var   logic        s_axi_rvalid_o,
   input  wire  logic        s_axi_rready_i,
   // Crystal and power state
   input  wire  logic        crystal_input_pin_i,
   input  wire  logic        sleep_deep_i,
   // Pins and status
   output var   logic [1:0]  compare_output_o,
   output var   logic [1:0]  compare_connect_o,
   output var   logic        crystal_pins_detach_o,
   output var   logic        osc_run_o,
   output var   logic        wake_req_o
);
   logic [7:0]  ctl_a_r, ctl_b_r, count_value_r, cnt_nxt, cnt_copy_r;
   logic        dn_r, dn_nxt, async_r;
   logic [2:0]  flg_r, irq_en_r, ev;
   logic [2:0]  evq_r [apt_pkg::FLG_DLY];
   logic [9:0]  pre_r;
   logic [9:0]  pmask;
   logic        xs1_r, xs2_r, xs3_r, xt_rise, src_en, tick;
   logic [7:0]  hold_r [apt_pkg::NBUF];
   logic [1:0]  edg_r  [apt_pkg::NBUF];
   logic [apt_pkg::NBUF-1:0] pend_r, app, wsel, upd;
   logic [7:0]  upd_d [apt_pkg::NBUF];
   logic [7:0]  cmp_buf_r [2];
   logic [7:0]  cmp_act_r [2];
   logic [1:0]  oc_r, match;
   logic        aw_got_r, w_got_r, wr_fire;
   logic [7:0]  aw_addr_r, rd_mux;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        rd_ok, wr_ok;
   logic [2:0]  wgm;
   logic        dual;
   logic [7:0]  top;
   logic        at_top;

   assign wgm  = {ctl_b_r[apt_pkg::WGM2_BIT], ctl_a_r[1:0]};
   assign dual = (wgm == apt_pkg::WGM_PC_FF) ||
                 (wgm == apt_pkg::WGM_PC_CA);
   assign top  = ctl_b_r[apt_pkg::WGM2_BIT] ? cmp_act_r[0] :
                 apt_pkg::CNT_MAX;

   // Crystal pin sampling; first stage feeds only the second
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         xs1_r <= 1'b0;
         xs2_r <= 1'b0;
         xs3_r <= 1'b0;
      end else begin
         xs1_r <= crystal_input_pin_i;
         xs2_r <= xs1_r;
         xs3_r <= xs2_r;
      end
   end
   // Oscillator halted in deep sleep, so no edges reach the timer
   assign xt_rise = async_r && !sleep_deep_i && xs2_r && !xs3_r;
   assign src_en  = async_r ? xt_rise : 1'b1;

   always_comb begin
      case (ctl_b_r[2:0])
         3'h2:    pmask = apt_pkg::PM_8;
         3'h3:    pmask = apt_pkg::PM_32;
         3'h4:    pmask = apt_pkg::PM_64;
         3'h5:    pmask = apt_pkg::PM_128;
         3'h6:    pmask = apt_pkg::PM_256;
         3'h7:    pmask = apt_pkg::PM_1024;
         default: pmask = apt_pkg::PM_1;
      endcase
   end
   // Code zero stops the timer
   assign tick = src_en && (ctl_b_r[2:0] != 3'h0) &&
                 ((pre_r & pmask) == pmask);

   always_ff @(posedge mclk_i) begin
      if (!rstn_i)
         pre_r <= 10'h000;
      else if (wsel[0] && aw_addr_r == apt_pkg::OFS_GEN &&
               w_data_r[apt_pkg::GEN_PSR])
         pre_r <= 10'h000;
      else if (src_en)
         pre_r <= pre_r + 10'h001;
   end

   // AXI4-Lite write channel
   assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid_o;
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         aw_got_r        <= 1'b0;
         w_got_r         <= 1'b0;
         aw_addr_r       <= 8'h00;
         w_data_r        <= 32'h0000_0000;
         w_strb_r        <= 4'h0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= apt_pkg::RESP_OK;
      end else begin
         s_axi_awready_o <= !aw_got_r && !(s_axi_awvalid_i && s_axi_awready_o);
         s_axi_wready_o  <= !w_got_r && !(s_axi_wvalid_i && s_axi_wready_o);
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= {s_axi_awaddr_i[7:2], 2'b00};
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_got_r  <= 1'b1;
            w_data_r <= s_axi_wdata_i;
            w_strb_r <= s_axi_wstrb_i;
         end
         if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_ok ? apt_pkg::RESP_OK : apt_pkg::RESP_ERR;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o  <= 1'b0;
            aw_got_r        <= 1'b0;
            w_got_r         <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
         end
      end
   end
   assign wr_ok = aw_addr_r <= apt_pkg::OFS_GEN;

   // Per-register holding path for async writes
   genvar k;
   generate
      for (k = 0; k < apt_pkg::NBUF; k++) begin : g_hold
         assign wsel[k] = wr_fire && w_strb_r[0] && (k == 0 ||
                          aw_addr_r == 8'(k * 4));
         assign app[k]  = pend_r[k] && xt_rise && (edg_r[k] == apt_pkg::XT_LAST);
         assign upd[k]  = async_r ? app[k] : (wsel[k] &&
                          aw_addr_r == 8'(k * 4));
         assign upd_d[k] = async_r ? hold_r[k] : w_data_r[7:0];
         always_ff @(posedge mclk_i) begin
            if (!rstn_i) begin
               hold_r[k] <= 8'h00;
               edg_r[k]  <= 2'h0;
               pend_r[k] <= 1'b0;
            end else if (async_r && wsel[k] && aw_addr_r == 8'(k * 4)) begin
               hold_r[k] <= w_data_r[7:0];
               edg_r[k]  <= 2'h0;
               pend_r[k] <= 1'b1;
            end else if (app[k]) begin
               pend_r[k] <= 1'b0;
            end else if (pend_r[k] && xt_rise) begin
               edg_r[k]  <= edg_r[k] + 2'h1;
            end
         end
      end
   endgenerate

   // Control registers and software-side bits
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         ctl_a_r  <= 8'h00;
         ctl_b_r  <= 8'h00;
         async_r  <= 1'b0;
         irq_en_r <= 3'h0;
      end else begin
         if (upd[apt_pkg::SL_CTL_A])
            ctl_a_r <= upd_d[apt_pkg::SL_CTL_A] & 8'hF3;
         if (upd[apt_pkg::SL_CTL_B])
            ctl_b_r <= upd_d[apt_pkg::SL_CTL_B] & 8'h0F;
         if (wsel[0] && aw_addr_r == apt_pkg::OFS_STATUS)
            async_r <= w_data_r[apt_pkg::STS_ASYNC];
         if (wsel[0] && aw_addr_r == apt_pkg::OFS_IRQ_EN)
            irq_en_r <= w_data_r[2:0];
      end
   end

   // Counter next state
   always_comb begin
      cnt_nxt = count_value_r;
      dn_nxt  = dn_r;
      if (tick) begin
         if (dual) begin
            if (!dn_r && count_value_r >= top) begin
               dn_nxt  = 1'b1;
               cnt_nxt = count_value_r - 8'h01;
            end else if (dn_r && count_value_r == apt_pkg::CNT_BOT) begin
               dn_nxt  = 1'b0;
               cnt_nxt = count_value_r + 8'h01;
            end else if (dn_r) begin
               cnt_nxt = count_value_r - 8'h01;
               dn_nxt  = (count_value_r != 8'h01);
            end else begin
               cnt_nxt = count_value_r + 8'h01;
            end
         end else begin
            dn_nxt  = 1'b0;
            cnt_nxt = count_value_r + 8'h01;
         end
      end
      if (upd[apt_pkg::SL_COUNT])
         cnt_nxt = upd_d[apt_pkg::SL_COUNT];
   end
   assign at_top = tick && dual && !dn_r && count_value_r >= top;

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         count_value_r <= 8'h00;
         dn_r          <= 1'b0;
         cnt_copy_r    <= 8'h00;
      end else begin
         count_value_r <= cnt_nxt;
         dn_r          <= dn_nxt;
         // Async copy lags until the next crystal edge after wake
         if (!async_r || xt_rise)
            cnt_copy_r <= count_value_r;
      end
   end

   // Overflow at BOTTOM
   assign ev[0] = tick && cnt_nxt == apt_pkg::CNT_BOT &&
                  count_value_r != apt_pkg::CNT_BOT;

   // Compare channels
   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_ch
         logic [1:0] act;
         logic       tog_ok;
         assign act    = ctl_a_r[(c == 0 ? apt_pkg::ACT_A_LSB :
                                  apt_pkg::ACT_B_LSB) +: 2];
         assign tog_ok = (c == 0) && ctl_b_r[apt_pkg::WGM2_BIT];
         // No match while a count write or this channel's compare write is in flight
         assign match[c] = tick && cnt_nxt == cmp_act_r[c] &&
                           !pend_r[apt_pkg::SL_COUNT] &&
                           !pend_r[apt_pkg::SL_CMP_A + 3'(c)];
         assign ev[c+1] = match[c];
         always_ff @(posedge mclk_i) begin
            if (!rstn_i) begin
               cmp_buf_r[c] <= 8'h00;
               cmp_act_r[c] <= 8'h00;
            end else begin
               if (upd[apt_pkg::SL_CMP_A + 3'(c)])
                  cmp_buf_r[c] <= upd_d[apt_pkg::SL_CMP_A + 3'(c)];
               // Update at TOP keeps each period symmetric
               if (!dual || at_top)
                  cmp_act_r[c] <= cmp_buf_r[c];
            end
         end
         always_ff @(posedge mclk_i) begin
            if (!rstn_i) begin
               oc_r[c] <= 1'b0;
            end else if (act == apt_pkg::ACT_TOG) begin
               if (tog_ok && match[c])
                  oc_r[c] <= !oc_r[c];
            end else if (tick && dual) begin
               if (match[c] && cmp_act_r[c] != top)
                  oc_r[c] <= dn_nxt;
               else if (cnt_nxt == top && cmp_act_r[c] >= top)
                  oc_r[c] <= 1'b1;
               else if (cnt_nxt == apt_pkg::CNT_BOT)
                  oc_r[c] <= cmp_act_r[c] != apt_pkg::CNT_BOT;
            end
         end
         // Driven straight from the timer state, no processor-side resync
         always_ff @(posedge mclk_i) begin
            if (!rstn_i) begin
               compare_output_o[c]  <= 1'b0;
               compare_connect_o[c] <= 1'b0;
            end else begin
               compare_output_o[c]  <= (act == apt_pkg::ACT_INV) ?
                                       !oc_r[c] : oc_r[c];
               compare_connect_o[c] <= (act == apt_pkg::ACT_NINV) ||
                                       (act == apt_pkg::ACT_INV) ||
                                       (act == apt_pkg::ACT_TOG && tog_ok);
            end
         end
      end
   endgenerate

   // Flags: async events wait three processor cycles; set beats clear
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         evq_r[0] <= 3'h0;
         evq_r[1] <= 3'h0;
         evq_r[2] <= 3'h0;
         flg_r    <= 3'h0;
      end else begin
         evq_r[0] <= ev;
         evq_r[1] <= evq_r[0];
         evq_r[2] <= evq_r[1];
         flg_r <= (flg_r & ~((wsel[0] && aw_addr_r == apt_pkg::OFS_FLAGS) ?
                  w_data_r[2:0] : 3'h0)) |
                  (async_r ? evq_r[apt_pkg::FLG_DLY-1] : ev);
      end
   end

   // Wake request and pin status
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         wake_req_o            <= 1'b0;
         crystal_pins_detach_o <= 1'b0;
         osc_run_o             <= 1'b0;
      end else begin
         if (tick)
            wake_req_o <= |(flg_r & irq_en_r);
         crystal_pins_detach_o <= async_r;
         osc_run_o             <= async_r && !sleep_deep_i;
      end
   end

   // AXI4-Lite read channel
   always_comb begin
      rd_ok  = 1'b1;
      case ({s_axi_araddr_i[7:2], 2'b00})
         apt_pkg::OFS_CTL_A:  rd_mux = ctl_a_r;
         apt_pkg::OFS_CTL_B:  rd_mux = ctl_b_r;
         apt_pkg::OFS_COUNT:  rd_mux = cnt_copy_r;
         apt_pkg::OFS_CMP_A:  rd_mux = cmp_buf_r[0];
         apt_pkg::OFS_CMP_B:  rd_mux = cmp_buf_r[1];
         apt_pkg::OFS_STATUS: rd_mux = {2'b00, async_r,
                                        pend_r[apt_pkg::SL_COUNT],
                                        pend_r[apt_pkg::SL_CMP_A],
                                        pend_r[apt_pkg::SL_CMP_B],
                                        pend_r[apt_pkg::SL_CTL_A],
                                        pend_r[apt_pkg::SL_CTL_B]};
         apt_pkg::OFS_FLAGS:  rd_mux = {5'h00, flg_r};
         apt_pkg::OFS_IRQ_EN: rd_mux = {5'h00, irq_en_r};
         apt_pkg::OFS_GEN:    rd_mux = 8'h00;
         default: begin
            rd_mux = 8'h00;
            rd_ok  = 1'b0;
         end
      endcase
   end
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= apt_pkg::RESP_OK;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rdata_o   <= {24'h00_0000, rd_mux};
         s_axi_rresp_o   <= rd_ok ? apt_pkg::RESP_OK : apt_pkg::RESP_ERR;
      end else if (s_axi_rvalid_o) begin
         if (s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
         end
      end else begin
         s_axi_arready_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// [apt_timer_sva.sv]
// Port-level checks for the dual-slope timer: bus handshakes and pins.
// Assumes it is bound onto apt_timer, one mclk_i domain.
`timescale 1ns/1ns
`default_nettype none
module apt_timer_sva (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rstn_i,
   // Register bus
   input  wire logic        s_axi_awvalid_i,
   input  wire logic        s_axi_awready_o,
   input  wire logic        s_axi_wvalid_i,
   input  wire logic        s_axi_wready_o,
   input  wire logic [1:0]  s_axi_bresp_o,
   input  wire logic        s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   input  wire logic        s_axi_arready_o,
   input  wire logic [31:0] s_axi_rdata_o,
   input  wire logic [1:0]  s_axi_rresp_o,
   input  wire logic        s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   // Pins
   input  wire logic        sleep_deep_i,
   input  wire logic        crystal_pins_detach_o,
   input  wire logic        osc_run_o,
   input  wire logic [1:0]  compare_output_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
      |=> s_axi_rvalid_o && !s_axi_arready_o)
      else $error("read answer missing");
   a_wr_answer: assert property (s_axi_awvalid_i && s_axi_awready_o &&
      s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
      else $error("write answer missing");
   a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
      else $error("read response dropped");
   a_b_release: assert property (s_axi_bvalid_o && s_axi_bready_i
      |=> !s_axi_bvalid_o)
      else $error("write response repeated");
   a_rd_unmapped: assert property (s_axi_arvalid_i && s_axi_arready_o &&
      s_axi_araddr_i[7:2] > apt_pkg::OFS_GEN[7:2] |=> s_axi_rresp_o ==
      apt_pkg::RESP_ERR && s_axi_rdata_o == 32'h0000_0000)
      else $error("unmapped read not refused");
   a_osc_detach: assert property (osc_run_o |-> crystal_pins_detach_o)
      else $error("oscillator runs with pins attached");
   a_deep_stop: assert property (sleep_deep_i |=> !osc_run_o)
      else $error("oscillator runs in deep sleep");

   c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
   c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
   c_pwm_rise: cover property ($rose(compare_output_o[0]));
   c_osc_on: cover property ($rose(osc_run_o));
endmodule

bind apt_timer apt_timer_sva u_sva (.mclk_i(mclk_i), .rstn_i(rstn_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
   .sleep_deep_i(sleep_deep_i), .osc_run_o(osc_run_o),
   .crystal_pins_detach_o(crystal_pins_detach_o),
   .compare_output_o(compare_output_o));
`default_nettype wire

// [apt_xtal_model.sv]
// Free-running watch crystal seen at the timer's crystal input pin.
// Assumes the system clock is far faster than this oscillator.
`timescale 1ns/1ns
`default_nettype none
module apt_xtal_model #(
   parameter int HALF_NS = 15259
) (
   // Crystal level
   output var logic xtal_o
);
   // Runs free: the oscillator never pauses between uses
   initial xtal_o = 1'b0;
   always #(HALF_NS) xtal_o = ~xtal_o;
endmodule
`default_nettype wire

// [test_async_phase_correct_pwm_timer.sv]
// Register-level bench for the dual-slope timer with crystal update path.
// Assumes the crystal model drives the crystal pin at about 32.768 kHz.
`timescale 1ns/1ns
`default_nettype none
module test_async_phase_correct_pwm_timer;
   localparam int XT_CYC = 763;
   localparam int LIMIT  = 60000;
   logic        mclk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [7:0]  s_axi_awaddr_i = 8'h00;
   logic        s_axi_awvalid_i = 1'b0;
   logic [31:0] s_axi_wdata_i = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb_i = 4'hF;
   logic        s_axi_wvalid_i = 1'b0;
   logic        s_axi_bready_i = 1'b0;
   logic [7:0]  s_axi_araddr_i = 8'h00;
   logic        s_axi_arvalid_i = 1'b0;
   logic        s_axi_rready_i = 1'b0;
   logic        sleep_deep_i = 1'b0;
   wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   wire         s_axi_arready_o, s_axi_rvalid_o, xtal;
   wire  [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   wire  [31:0] s_axi_rdata_o;
   wire  [1:0]  compare_output_o, compare_connect_o;
   wire         crystal_pins_detach_o, osc_run_o, wake_req_o;
   int          err_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   logic [31:0] v;
   logic [1:0]  rr;
   int          t;

   apt_xtal_model u_xtal (.xtal_o(xtal));
   apt_timer dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
      .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
      .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
      .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
      .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
      .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
      .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
      .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
      .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
      .s_axi_rready_i(s_axi_rready_i), .crystal_input_pin_i(xtal),
      .sleep_deep_i(sleep_deep_i), .compare_output_o(compare_output_o),
      .compare_connect_o(compare_connect_o), .osc_run_o(osc_run_o),
      .crystal_pins_detach_o(crystal_pins_detach_o),
      .wake_req_o(wake_req_o));

   always #20 mclk_i = ~mclk_i;

   task automatic end_sim();
      if (err_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // A hung handshake or a missing PWM edge ends here
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == LIMIT) begin
         err_count++;
         end_sim();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er = apt_pkg::RESP_OK);
      logic aw_t, w_t;
      aw_t = 1'b0;
      w_t = 1'b0;
      @(posedge mclk_i);
      s_axi_awaddr_i <= a;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wdata_i <= {24'h00_0000, d};
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      while (!(aw_t && w_t)) begin
         @(posedge mclk_i);
         if (!aw_t && s_axi_awready_o) begin
            aw_t = 1'b1;
            s_axi_awvalid_i <= 1'b0;
         end
         if (!w_t && s_axi_wready_o) begin
            w_t = 1'b1;
            s_axi_wvalid_i <= 1'b0;
         end
      end
      do @(posedge mclk_i); while (s_axi_bvalid_o !== 1'b1);
      s_axi_bready_i <= 1'b0;
      check({30'h0, s_axi_bresp_o}, {30'h0, er});
   endtask

   task automatic rdv(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      @(posedge mclk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do @(posedge mclk_i); while (s_axi_arready_o !== 1'b1);
      s_axi_arvalid_i <= 1'b0;
      do @(posedge mclk_i); while (s_axi_rvalid_o !== 1'b1);
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      s_axi_rready_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er = apt_pkg::RESP_OK);
      logic [31:0] d;
      logic [1:0]  r;
      rdv(a, d, r);
      check(d, exp);
      check({30'h0, r}, {30'h0, er});
   endtask

   // Third period is measured: the first two may straddle a TOP reload
   task automatic pwm(input int ch, input int exp_per, input int exp_hi);
      logic p;
      int   per, hi;
      repeat (3) begin
         per = 0;
         hi = 0;
         do begin
            p = compare_output_o[ch];
            @(posedge mclk_i);
            per++;
            if (compare_output_o[ch] === 1'b1) hi++;
         end while (!(p === 1'b0 && compare_output_o[ch] === 1'b1));
      end
      check(32'(per), 32'(exp_per));
      check(32'(hi), 32'(exp_hi));
   endtask

   task automatic level(input int ch, input logic exp);
      int bad;
      bad = 0;
      repeat (600) @(posedge mclk_i);
      repeat (600) begin
         @(posedge mclk_i);
         if (compare_output_o[ch] !== exp) bad++;
      end
      check(32'(bad), 32'h0);
   endtask

   initial begin
      repeat (10) @(posedge mclk_i);
      rstn_i <= 1'b1;
      rd(apt_pkg::OFS_CTL_A, 32'h0);
      rd(apt_pkg::OFS_STATUS, 32'h0);
      rd(8'h24, 32'h0, apt_pkg::RESP_ERR);
      wr(8'h24, 8'h5A, apt_pkg::RESP_ERR);
      // Mode 1, no prescale, channel A non-inverted then inverted
      wr(apt_pkg::OFS_CTL_B, 8'h01);
      wr(apt_pkg::OFS_CMP_A, 8'h80);
      wr(apt_pkg::OFS_CTL_A, 8'h81);
      pwm(0, 510, 256);
      check(32'(compare_connect_o[0]), 32'h1);
      wr(apt_pkg::OFS_CTL_A, 8'hC1);
      pwm(0, 510, 254);
      wr(apt_pkg::OFS_CMP_A, 8'hFF);
      level(0, 1'b0);
      wr(apt_pkg::OFS_CTL_A, 8'h81);
      level(0, 1'b1);
      wr(apt_pkg::OFS_CMP_A, 8'h00);
      level(0, 1'b0);
      rdv(apt_pkg::OFS_FLAGS, v, rr);
      check(32'(v[0]), 32'h1);
      wr(apt_pkg::OFS_CTL_B, 8'h00);
      wr(apt_pkg::OFS_FLAGS, 8'h01);
      rdv(apt_pkg::OFS_FLAGS, v, rr);
      check(32'(v[0]), 32'h0);
      // Mode 5: TOP from compare A, channel B carries the PWM
      wr(apt_pkg::OFS_CMP_A, 8'h40);
      wr(apt_pkg::OFS_CMP_B, 8'h20);
      wr(apt_pkg::OFS_CTL_A, 8'h21);
      wr(apt_pkg::OFS_CTL_B, 8'h09);
      pwm(1, 128, 64);
      wr(apt_pkg::OFS_CTL_A, 8'h61);
      @(posedge mclk_i);
      check({30'h0, compare_connect_o}, 32'h3);
      wr(apt_pkg::OFS_CTL_B, 8'h01);
      @(posedge mclk_i);
      check({30'h0, compare_connect_o}, 32'h2);
      wr(apt_pkg::OFS_CTL_A, 8'h11);
      @(posedge mclk_i);
      check({30'h0, compare_connect_o}, 32'h0);
      // Prescale by 8 from a cleared prescaler phase
      wr(apt_pkg::OFS_CMP_A, 8'h80);
      wr(apt_pkg::OFS_CTL_A, 8'h81);
      wr(apt_pkg::OFS_CTL_B, 8'h02);
      wr(apt_pkg::OFS_GEN, 8'h02);
      pwm(0, 4080, 2048);
      // Safe switch to the crystal, then held writes
      wr(apt_pkg::OFS_IRQ_EN, 8'h00);
      wr(apt_pkg::OFS_STATUS, 8'h20);
      repeat (2) @(posedge mclk_i);
      check({30'h0, crystal_pins_detach_o, osc_run_o}, 32'h3);
      for (int i = 0; i < 2; i++) begin
         wr(i == 0 ? apt_pkg::OFS_COUNT : apt_pkg::OFS_CMP_A, 8'h40);
         t = cyc;
         rdv(apt_pkg::OFS_STATUS, v, rr);
         check(32'(v[4 - i]), 32'h1);
         // Next write waits for the busy flag to drop
         while (v[4 - i] === 1'b1) rdv(apt_pkg::OFS_STATUS, v, rr);
         check(32'(cyc - t >= XT_CYC - 10 && cyc - t <= 2 * XT_CYC + 10),
               32'h1);
      end
      wr(apt_pkg::OFS_FLAGS, 8'h07);
      @(posedge mclk_i);
      sleep_deep_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      check(32'(osc_run_o), 32'h0);
      sleep_deep_i <= 1'b0;
      end_sim();
   end
endmodule
`default_nettype wire
